// ===== hw/chopper_regs.vh
// Behaviour
// R1 - Frequency codes 0, 2, 3 give 2/1024, 2/512, 2/410 of clock.
// R2 - Frequency code 1 gives 2/683 of the clock frequency.
// R3 - Drive polarity toggles once per chopper cycle; each output pulses once every two cycles, half the chopper rate.
// R4 - With autoscale on, loop gain 1..15 steps scale 0.5..7.5 per fullstep.
// R5 - User offset 0..255 feeds amplitude and seeds the tuned offset.
// R6 - User gradient 0..255 feeds amplitude and seeds the tuned gradient.
// R7 - With gradient autotune off, the user gradient replaces the tuned one.
// R8 - Standstill option acts only at zero hold current in voltage mode.
// R9 - Tuned scale readable, magnitude up to 255, frozen in current mode.
// R10 - Tuned offset and gradient are readable, range 0..255.
// R11 - Nonzero off-time field enables the driver; its value is otherwise unused.
// R12 - Comparator blanked after each switch; setting 0 is 16 clocks.
// R13 - Host writes to tuned readback values are ignored.
`ifndef CHOPPER_REGS_VH
`define CHOPPER_REGS_VH
`define CTRL_ADDR 4'h0
`define AMP_ADDR 4'h4
`define STAT_ADDR 4'h8
`define CTRL_OFFTIME_LSB 0
`define CTRL_BLANK_LSB 4
`define CTRL_FREQ_LSB 6
`define CTRL_AUTOSCALE_BIT 8
`define CTRL_AUTOGRAD_BIT 9
`define CTRL_STANDSTILL_LSB 10
`define CTRL_VMODE_BIT 12
`define CTRL_HOLD_LSB 16
`define AMP_OFS_LSB 0
`define AMP_GRAD_LSB 8
`define AMP_GAIN_LSB 16
`define STAT_SCALE_LSB 0
`define STAT_OFS_LSB 12
`define STAT_GRAD_LSB 20
`define CTRL_RESET 32'h0000_1000
`define AMP_RESET 32'h0004_001E
`define MOD_CODE0 11'h400
`define MOD_CODE1 11'h2AB
`define MOD_CODE2 11'h200
`define MOD_CODE3 11'h19A
`define BLANK_SET0 6'h10
`define BLANK_SET1 6'h18
`define BLANK_SET2 6'h24
`define BLANK_SET3 6'h36
`define SCALE_LIMIT 10'h1FE
`endif

// ===== hw/chopper_divider.v
`timescale 1ns/100ps
`default_nettype none
// Counts in half-clock units so odd moduli such as 683 average exactly.
module chopper_divider #(
  parameter W = 11
) (
  // Clock and reset.
  input wire mclk_in,
  input wire rst_in,
  // Modulus in half-clock units.
  input wire [W-1:0] modulus_in,
  // Phase and cycle wrap.
  output reg [W-1:0] phase_out,
  output reg wrap_out
);

  wire [W:0] sum;
  wire [W:0] rem;
  assign sum = {1'b0, phase_out} + {{(W-1){1'b0}}, 2'h2};
  assign rem = sum - {1'b0, modulus_in};

  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_out <= {W{1'b0}};
      wrap_out <= 1'b0;
    end else if (sum >= {1'b0, modulus_in}) begin
      phase_out <= rem[W-1:0]; // see R1
      wrap_out <= 1'b1;
    end else begin
      phase_out <= sum[W-1:0];
      wrap_out <= 1'b0;
    end
  end

endmodule // chopper_divider
`default_nettype wire

// ===== hw/chopper_config.v
`timescale 1ns/100ps
`default_nettype none
`include "chopper_regs.vh"
module chopper_config #(
  parameter GRAD_VEL_MIN = 8'h40
) (
  // Clock and reset.
  input wire mclk_in,
  input wire rst_in,
  // AHB-Lite slave.
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire hready_in,
  input wire [31:0] hwdata_in,
  output reg [31:0] hrdata_out,
  output reg hreadyout_out,
  output reg hresp_out,
  // Motion and sensing.
  input wire fullstep_in,
  input wire [7:0] velocity_in,
  input wire standstill_in,
  input wire current_mode_in,
  input wire comparator_in,
  // Bridge gates and blanking state.
  output reg coil_hs_a_out,
  output reg coil_ls_a_out,
  output reg coil_hs_b_out,
  output reg coil_ls_b_out,
  output reg blanking_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  reg [31:0] ctrl_ff;
  reg [31:0] amp_ff;
  reg wr_pend_ff;
  reg [3:0] wr_addr_ff;
  reg signed [9:0] scale_ff;
  reg [7:0] ofs_tuned_ff;
  reg [7:0] grad_tuned_ff;
  reg [31:0] nxt_rdata;
  wire take;
  wire [31:0] stat_word;

  assign take = hsel_in & htrans_in[1] & hready_in;
  // Magnitude is kept in half steps internally; only whole steps are shown.
  assign stat_word = {4'h0, grad_tuned_ff, ofs_tuned_ff, 3'h0, scale_ff[9:1]}; // see R9 see R10

  always @* begin
    case (haddr_in[3:0])
      `CTRL_ADDR: nxt_rdata = ctrl_ff;
      `AMP_ADDR: nxt_rdata = amp_ff;
      `STAT_ADDR: nxt_rdata = stat_word;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 4'h0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      wr_pend_ff <= take & hwrite_in;
      if (take) begin
        wr_addr_ff <= haddr_in[3:0];
      end
      if (take & ~hwrite_in) begin
        hrdata_out <= nxt_rdata;
      end
    end
  end

  // The status word has no write path at all, so software cannot disturb tuning.
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_ff <= `CTRL_RESET;
      amp_ff <= `AMP_RESET;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == `CTRL_ADDR) begin
        ctrl_ff <= {11'h000, hwdata_in[20:16], 3'h0, hwdata_in[12:0]};
      end
      if (wr_addr_ff == `AMP_ADDR) begin
        amp_ff <= {12'h000, hwdata_in[19:0]}; // see R13
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode.

  wire [3:0] driver_off_time_enable;
  wire [1:0] comparator_blanking_select;
  wire [1:0] freq_sel;
  wire autoscale;
  wire autograd;
  wire [1:0] standstill_option;
  wire vmode;
  wire [4:0] hold_current;
  wire [7:0] amplitude_offset_user;
  wire [7:0] amplitude_gradient_user;
  wire [3:0] loop_gain;
  wire drv_en;

  assign driver_off_time_enable = ctrl_ff[`CTRL_OFFTIME_LSB +: 4];
  assign comparator_blanking_select = ctrl_ff[`CTRL_BLANK_LSB +: 2];
  assign freq_sel = ctrl_ff[`CTRL_FREQ_LSB +: 2];
  assign autoscale = ctrl_ff[`CTRL_AUTOSCALE_BIT];
  assign autograd = ctrl_ff[`CTRL_AUTOGRAD_BIT];
  assign standstill_option = ctrl_ff[`CTRL_STANDSTILL_LSB +: 2];
  assign vmode = ctrl_ff[`CTRL_VMODE_BIT];
  assign hold_current = ctrl_ff[`CTRL_HOLD_LSB +: 5];
  assign amplitude_offset_user = amp_ff[`AMP_OFS_LSB +: 8]; // see R5
  assign amplitude_gradient_user = amp_ff[`AMP_GRAD_LSB +: 8]; // see R6
  assign loop_gain = amp_ff[`AMP_GAIN_LSB +: 4];
  assign drv_en = (driver_off_time_enable != 4'h0); // see R11

  ////////////////////////////////////////////////////////////////////////////
  // Chopper timebase.

  reg [10:0] modulus;
  wire [10:0] phase;
  wire wrap;

  always @* begin
    case (freq_sel)
      2'h0: modulus = `MOD_CODE0; // see R1
      2'h1: modulus = `MOD_CODE1; // see R2
      2'h2: modulus = `MOD_CODE2; // see R1
      default: modulus = `MOD_CODE3; // see R1
    endcase
  end

  chopper_divider #(
    .W(11)
  ) u_div (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .modulus_in(modulus),
    .phase_out(phase),
    .wrap_out(wrap)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Amplitude regulation and autotuning.

  reg cmp_hold_ff;
  wire [3:0] gain_eff;
  wire signed [10:0] scale_up;
  wire signed [10:0] scale_dn;
  wire regulate;
  wire [7:0] grad_eff;

  // A zero gain is not a legal setting; treat it as the smallest step.
  assign gain_eff = (loop_gain == 4'h0) ? 4'h1 : loop_gain;
  assign scale_up = {scale_ff[9], scale_ff} + {7'h00, gain_eff};
  assign scale_dn = {scale_ff[9], scale_ff} - {7'h00, gain_eff};
  assign regulate = fullstep_in & autoscale & vmode & ~current_mode_in; // see R9
  assign grad_eff = autograd ? grad_tuned_ff : amplitude_gradient_user; // see R7

  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      scale_ff <= 10'h000;
    end else if (regulate) begin
      // Comparator high means the coil current ran over target.
      if (cmp_hold_ff) begin
        scale_ff <= (scale_dn < -$signed({1'b0, `SCALE_LIMIT})) ? -$signed(`SCALE_LIMIT) : scale_dn[9:0]; // see R4
      end else begin
        scale_ff <= (scale_up > $signed({1'b0, `SCALE_LIMIT})) ? `SCALE_LIMIT : scale_up[9:0]; // see R4
      end
    end
  end

  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ofs_tuned_ff <= 8'h00;
      grad_tuned_ff <= 8'h00;
    end else if (~autoscale) begin
      ofs_tuned_ff <= amplitude_offset_user; // see R5
      grad_tuned_ff <= amplitude_gradient_user; // see R6
    end else if (regulate) begin
      if (velocity_in < GRAD_VEL_MIN) begin
        if (~scale_ff[9] && scale_ff[9:1] != 9'h000 && ofs_tuned_ff != 8'hFF) begin
          ofs_tuned_ff <= ofs_tuned_ff + 8'h01; // see R10
        end else if (scale_ff[9] && ofs_tuned_ff != 8'h00) begin
          ofs_tuned_ff <= ofs_tuned_ff - 8'h01; // see R10
        end
      end else if (autograd) begin
        if (~scale_ff[9] && scale_ff[9:1] != 9'h000 && grad_tuned_ff != 8'hFF) begin
          grad_tuned_ff <= grad_tuned_ff + 8'h01; // see R10
        end else if (scale_ff[9] && grad_tuned_ff != 8'h00) begin
          grad_tuned_ff <= grad_tuned_ff - 8'h01; // see R10
        end
      end else begin
        grad_tuned_ff <= amplitude_gradient_user; // see R7
      end
    end
  end

  wire [15:0] grad_prod;
  wire [10:0] amp_sum;
  wire [10:0] amp_scaled;
  wire [7:0] amplitude;
  wire [18:0] on_prod;
  wire [10:0] on_limit;

  assign grad_prod = grad_eff * velocity_in;
  assign amp_sum = {3'h0, (autoscale ? ofs_tuned_ff : amplitude_offset_user)} + {3'h0, grad_prod[15:8]};
  assign amp_scaled = amp_sum + {{2{scale_ff[9]}}, scale_ff[9:1]};
  assign amplitude = amp_scaled[10] ? 8'h00 : (amp_scaled[9:8] != 2'h0) ? 8'hFF : amp_scaled[7:0];
  assign on_prod = amplitude * modulus;
  assign on_limit = on_prod[18:8];

  ////////////////////////////////////////////////////////////////////////////
  // Blanking and comparator capture.

  reg [5:0] blank_ff;
  reg [5:0] blank_len;

  always @* begin
    case (comparator_blanking_select)
      2'h0: blank_len = `BLANK_SET0; // see R12
      2'h1: blank_len = `BLANK_SET1;
      2'h2: blank_len = `BLANK_SET2;
      default: blank_len = `BLANK_SET3;
    endcase
  end

  localparam ST_DRIVE = 3'b001;
  localparam ST_FREE = 3'b010;
  localparam ST_BRAKE = 3'b100;

  reg [2:0] state;
  reg [2:0] state_ff;
  reg on_ff;
  wire nxt_on;
  assign nxt_on = (phase < on_limit) & drv_en;

  // The comparator rings after every switching edge, so it is ignored meanwhile.
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      blank_ff <= 6'h00;
      blanking_out <= 1'b0;
      cmp_hold_ff <= 1'b0;
      state_ff <= ST_FREE;
    end else begin
      state_ff <= state;
      // Entering or leaving a bridge mode switches the gates as well.
      if ((nxt_on != on_ff) || (state != state_ff)) begin
        blank_ff <= blank_len; // see R12
        blanking_out <= 1'b1;
      end else if (blank_ff > 6'h01) begin
        blank_ff <= blank_ff - 6'h01;
      end else begin
        blank_ff <= 6'h00;
        blanking_out <= 1'b0;
      end
      if (blank_ff == 6'h00 && on_ff) begin
        cmp_hold_ff <= comparator_in; // see R12
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bridge drive.

  reg polarity_ff;
  wire pol_now;

  // A wrap flagged now already starts the new half period; waiting for the flop would glitch a gate.
  assign pol_now = polarity_ff ^ wrap; // see R3

  always @* begin
    if (drv_en & standstill_in & vmode & (hold_current == 5'h00) & (standstill_option != 2'h0)) begin
      state = (standstill_option == 2'h1) ? ST_FREE : ST_BRAKE; // see R8
    end else if (drv_en) begin
      state = ST_DRIVE; // see R11
    end else begin
      state = ST_FREE;
    end
  end

  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      polarity_ff <= 1'b0;
      on_ff <= 1'b0;
      coil_hs_a_out <= 1'b0;
      coil_ls_a_out <= 1'b0;
      coil_hs_b_out <= 1'b0;
      coil_ls_b_out <= 1'b0;
    end else begin
      if (wrap) begin
        polarity_ff <= ~polarity_ff; // see R3
      end
      on_ff <= nxt_on;
      case (state)
        ST_DRIVE: begin
          // Off phase recirculates through both low sides.
          coil_hs_a_out <= nxt_on & ~pol_now;
          coil_ls_b_out <= ~nxt_on | ~pol_now;
          coil_hs_b_out <= nxt_on & pol_now;
          coil_ls_a_out <= ~nxt_on | pol_now;
        end
        ST_BRAKE: begin
          coil_hs_a_out <= (standstill_option == 2'h3);
          coil_hs_b_out <= (standstill_option == 2'h3);
          coil_ls_a_out <= (standstill_option == 2'h2);
          coil_ls_b_out <= (standstill_option == 2'h2);
        end
        default: begin
          coil_hs_a_out <= 1'b0;
          coil_ls_a_out <= 1'b0;
          coil_hs_b_out <= 1'b0;
          coil_ls_b_out <= 1'b0;
        end
      endcase
    end
  end

endmodule // chopper_config
`default_nettype wire

// ===== bench/chopper_chk.sv
`timescale 1ns/100ps
`default_nettype none
module chopper_chk (
  // Clock, reset and bus.
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  // Motion and bridge.
  input wire logic standstill_in,
  input wire logic coil_hs_a_out,
  input wire logic coil_ls_a_out,
  input wire logic coil_hs_b_out,
  input wire logic coil_ls_b_out,
  input wire logic blanking_out
);
  logic wr_ff;
  logic [31:0] ctrl_ff;
  logic [7:0] run_ff;
  logic [7:0] need;
  logic [3:0] g;
  logic ss;
  assign g = {coil_hs_a_out, coil_ls_a_out, coil_hs_b_out, coil_ls_b_out};
  assign ss = standstill_in && ctrl_ff[20:16] == 5'h0 && ctrl_ff[12] && ctrl_ff[3:0] != 4'h0;
  assign need = ctrl_ff[5] ? (ctrl_ff[4] ? 8'h36 : 8'h24) : (ctrl_ff[4] ? 8'h18 : 8'h10);
  // Shadow of the control word, so the rules can be judged without a view of the bodies.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ff <= 1'b0;
      ctrl_ff <= 32'h0000_1000;
      run_ff <= 8'h00;
    end else begin
      wr_ff <= hsel_in && htrans_in[1] && hwrite_in && haddr_in[3:0] == 4'h0;
      if (wr_ff) ctrl_ff <= hwdata_in;
      run_ff <= blanking_out ? run_ff + {7'h0, run_ff != 8'hFF} : 8'h00;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  AST_ZERO_WAIT: assert property (hreadyout_out && !hresp_out)
    else $error("bus answer not zero wait OKAY");
  AST_DRIVER_OFF: assert property ((ctrl_ff[3:0] == 4'h0) [*3] |-> g == 4'h0)
    else $error("gates active with driver off");
  AST_COAST_OFF: assert property ((ss && ctrl_ff[11:10] == 2'h1) [*3] |-> g == 4'h0)
    else $error("coast option not all off");
  AST_LS_BRAKE: assert property ((ss && ctrl_ff[11:10] == 2'h2) [*3] |-> g == 4'h5)
    else $error("low side brake wrong");
  AST_HS_BRAKE: assert property ((ss && ctrl_ff[11:10] == 2'h3) [*3] |-> g == 4'hA)
    else $error("high side brake wrong");
  AST_NO_SHOOT: assert property (!(g[3] && g[2]) && !(g[1] && g[0]))
    else $error("both switches of a leg on");
  AST_BLANK_START: assert property ($changed(g) && ctrl_ff[3:0] != 4'h0 && !standstill_in
    |-> ##[0:2] blanking_out)
    else $error("no blanking after switching");
  AST_BLANK_LEN: assert property ($fell(blanking_out) |-> run_ff >= need)
    else $error("blanking shorter than selected");
endmodule // chopper_chk
bind chopper_config chopper_chk chk (.mclk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in,
  .hwrite_in, .hwdata_in, .hreadyout_out, .hresp_out, .standstill_in, .coil_hs_a_out,
  .coil_ls_a_out, .coil_hs_b_out, .coil_ls_b_out, .blanking_out);
`default_nettype wire

// ===== bench/bridge_model.sv
`timescale 1ns/100ps
`default_nettype none
module bridge_model (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_in,
  // Gates and sense overrides.
  input wire logic [3:0] gate_in,
  input wire logic force_hi_in,
  input wire logic force_lo_in,
  // Sense comparator.
  output logic comparator_out
);
  logic [7:0] amps_ff;
  // Coil A current ramps while its high side conducts and decays otherwise.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) amps_ff <= 8'h00;
    else if (gate_in[3] && amps_ff != 8'hFF) amps_ff <= amps_ff + 8'h01;
    else if (!gate_in[3] && amps_ff != 8'h00) amps_ff <= amps_ff - 8'h01;
  end
  assign comparator_out = force_hi_in || (!force_lo_in && amps_ff > 8'h80);
endmodule // bridge_model
`default_nettype wire

// ===== bench/voltage_mode_chopper_config_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module voltage_mode_chopper_config_tb_top;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic fstep = 1'b0;
  logic still = 1'b0;
  logic cmode = 1'b0;
  logic f_hi = 1'b0;
  logic f_lo = 1'b0;
  logic [31:0] rdata;
  wire [31:0] hrdata;
  wire [3:0] g;
  wire hrdy;
  wire cmp;
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  int per [4] = '{1024, 683, 512, 410};
  int brk [4] = '{0, 0, 5, 10};
  always #12.5 mclk_in = ~mclk_in;
  chopper_config dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hrdy),
    .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(),
    .fullstep_in(fstep), .velocity_in(8'h80), .standstill_in(still), .current_mode_in(cmode),
    .comparator_in(cmp), .coil_hs_a_out(g[3]), .coil_ls_a_out(g[2]), .coil_hs_b_out(g[1]),
    .coil_ls_b_out(g[0]), .blanking_out()
  );
  bridge_model br (.mclk_in(mclk_in), .rst_in(rst_in), .gate_in(g), .force_hi_in(f_hi),
    .force_lo_in(f_lo), .comparator_out(cmp));
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_rdy;
    int k;
    k = 0;
    @(posedge mclk_in);
    while (hrdy !== 1'b1) begin
      k++;
      if (k > 50) begin
        chk("bus timeout", 32'h0, 32'h1);
        close_out;
      end
      @(posedge mclk_in);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rdata = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e, input string w);
    bus(1'b0, a, 32'h0);
    chk(w, e, rdata & m);
  endtask
  task automatic steps(input int k);
    repeat (k) begin
      @(posedge mclk_in);
      fstep <= 1'b1;
      @(posedge mclk_in);
      fstep <= 1'b0;
      repeat (3) @(posedge mclk_in);
    end
  endtask
  // A rise needs a low sample first, so the count is one full output period.
  task automatic rise(output int k);
    logic was;
    k = 0;
    was = 1'b1;
    forever begin
      @(posedge mclk_in);
      k++;
      if (g[3] === 1'b1 && was === 1'b0) break;
      was = g[3];
      if (k > 3000) begin
        chk("rise timeout", 32'h0, 32'h1);
        close_out;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd(32'h0, 32'hFFFF_FFFF, 32'h0000_1000, "ctrl");
    rd(32'h4, 32'hFFFF_FFFF, 32'h0004_001E, "amp");
    rd(32'h8, 32'hFFFF_FFFF, 32'h0001_E000, "status");
    rd(32'hC, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
    bus(1'b1, 32'h4, 32'h0004_3CA5);
    bus(1'b1, 32'h8, 32'hFFFF_FFFF);
    rd(32'h8, 32'hFFFF_FFFF, 32'h03CA_5000, "tuned");
    f_lo <= 1'b1;
    bus(1'b1, 32'h0, 32'h0000_1100);
    steps(5);
    rd(32'h8, 32'h0FF0_01FF, 32'h03C0_000A, "scale up");
    cmode <= 1'b1;
    steps(3);
    rd(32'h8, 32'h0000_01FF, 32'h0000_000A, "frozen");
    cmode <= 1'b0;
    bus(1'b1, 32'h4, 32'h000F_3CA5);
    steps(40);
    rd(32'h8, 32'h0000_01FF, 32'h0000_00FF, "clamp");
    f_lo <= 1'b0;
    f_hi <= 1'b1;
    // The comparator is captured only while the bridge drives and blanking is over.
    bus(1'b1, 32'h0, 32'h0000_1131);
    repeat (100) @(posedge mclk_in);
    steps(2);
    rd(32'h8, 32'h0000_01FF, 32'h0000_00F0, "scale down");
    f_hi <= 1'b0;
    // Blanking select falls with the code so a running blank never meets a longer setting.
    for (int c = 3; c >= 0; c--) begin
      bus(1'b1, 32'h0, 32'h0000_1001 | (c << 6) | (c << 4));
      repeat (3) rise(n);
      chk("period", per[c], n);
    end
    bus(1'b1, 32'h0, 32'h0000_100F);
    repeat (3) rise(n);
    chk("period enable", per[0], n);
    still <= 1'b1;
    for (int o = 1; o < 4; o++) begin
      bus(1'b1, 32'h0, 32'h0000_1001 | (o << 10));
      repeat (4) @(posedge mclk_in);
      chk("brake", brk[o], {28'h0, g});
    end
    bus(1'b1, 32'h0, 32'h0001_1401);
    rise(n);
    chk("hold drive", 32'h1, {31'h0, n <= 1100});
    bus(1'b1, 32'h0, 32'h0000_1000);
    repeat (4) @(posedge mclk_in);
    chk("driver off", 32'h0, {28'h0, g});
    still <= 1'b0;
    close_out;
  end
endmodule // voltage_mode_chopper_config_tb_top
`default_nettype wire
